// ---- logic/adc_ctl_pkg.sv ----
/*
  constants for the converter control block: register indices, field
  positions, reset values, channel codes and conversion lengths.
  assumes word-wide wishbone access with byte address = 4 * index.
*/
package adc_ctl_pkg;

  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_RESULT_LO = 7'h78;
  localparam logic [6:0] IDX_RESULT_HI = 7'h79;
  localparam logic [6:0] IDX_CTRL_A    = 7'h7A;
  localparam logic [6:0] IDX_CTRL_B    = 7'h7B;
  localparam logic [6:0] IDX_INPUT_SEL = 7'h7C;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // converter_control_status_a fields
  localparam int CSA_ENABLE = 7;
  localparam int CSA_START  = 6;
  localparam int CSA_AUTO   = 5;
  localparam int CSA_FLAG   = 4;
  localparam int CSA_IE     = 3;
  localparam int CSA_PS_HI  = 2;

  // converter_control_status_b fields
  localparam int CSB_CMP_MUX = 6;
  localparam int CSB_TS_HI   = 2;

  // input_select_register fields
  localparam int ISR_REF_HI = 7;
  localparam int ISR_REF_LO = 6;
  localparam int ISR_LADJ   = 5;
  localparam int ISR_MUX_HI = 4;

  // channel codes
  localparam logic [4:0] MUX_SE_LAST   = 5'h07;
  localparam logic [4:0] MUX_GAIN_LAST = 5'h0F;
  localparam logic [4:0] MUX_NEG1_LAST = 5'h17;
  localparam logic [4:0] MUX_DIFF_LAST = 5'h1D;
  localparam logic [4:0] MUX_BANDGAP   = 5'h1E;
  localparam logic [4:0] MUX_GROUND    = 5'h1F;

  localparam logic [1:0] GAIN_1X   = 2'h0;
  localparam logic [1:0] GAIN_10X  = 2'h1;
  localparam logic [1:0] GAIN_200X = 2'h2;

  localparam logic [1:0] NEG_IN0 = 2'h0;
  localparam logic [1:0] NEG_IN1 = 2'h1;
  localparam logic [1:0] NEG_IN2 = 2'h2;

  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  // conversion lengths in converter clock cycles
  localparam logic [4:0] INIT_CYCLES   = 5'd25;
  localparam logic [4:0] NORMAL_CYCLES = 5'd13;

  typedef struct packed {
    logic [2:0] pos;
    logic [1:0] neg;
    logic [1:0] gain;
    logic       single;
    logic       diff;
    logic       bandgap;
    logic       ground;
  } route_t;

  typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} conv_state_t;

endpackage

// ---- logic/adc_prescaler.sv ----
/*
  converter clock divider: a one-cycle enable pulse every 2..128 system
  clocks. assumes the select field is stable while the converter runs.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_prescaler (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  output var  logic       tick
);
  localparam logic [6:0] CNT_ZERO = 7'h00;
  localparam logic [6:0] CNT_ONE  = 7'h01;

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [6:0] last_cnt;
  logic       wrap;

  // codes 000 and 001 both divide by two
  assign last_cnt = (div_sel < 3'h2) ? CNT_ONE : 7'((8'h01 << div_sel) - 8'h01);
  assign wrap     = (cnt_r >= last_cnt);
  // held at zero while off so enabling always restarts a full period
  assign cnt_nxt  = (!run || wrap) ? CNT_ZERO : 7'(cnt_r + CNT_ONE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= CNT_ZERO;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= run && wrap;
    end
  end
endmodule

`default_nettype wire

// ---- logic/adc_control.sv ----
/*
  converter control and result registers behind a classic wishbone slave:
  channel routing, start / auto-trigger sequencing, completion flag and
  interrupt request, result lock and adjustment, comparator input routing.
  assumes a converter core on the same clock that presents its 10-bit code
  on core_result when conv_sample pulses, and asynchronous trigger sources.
*/
// Local design decision: the Wishbone slave port.
// Notes on behaviour
// - codes 0-7 pick single inputs 0-7; 30 bandgap; 31 ground.
// - codes 8-29 pick differential pairs with their negative input and gain.
// - channel changes during a conversion apply only after it completes.
// - enable bit turns converter on; clearing it aborts a running conversion.
// - writing start launches one conversion; in free running only the first.
// - first conversion after enabling takes 25 converter clocks, others 13.
// - start bit reads one while converting; writing zero does nothing.
// - with auto-trigger set, a rising edge of selected trigger starts conversion unless one is still running; edges while busy are lost.
// - done flag sets when conversion finishes, whether or not a locked result is updated.
// - done flag clears when vector is taken or software writes one.
// - interrupt request while flag, interrupt enable and global enable all set.
// - divider field gives 2,2,4,8,16,32,64,128 system clocks per converter clock.
// - result low byte at index 0x78, high byte at 0x79.
// - after low byte read, result is frozen until high byte read.
// - right adjust uses bits 9:0, left adjust bits 15:6, rest zero.
// - differential results are presented as two's complement.
// - comparator negative input from channel mux when enabled and converter off.
// - left-adjust change reshapes the result immediately, even mid-conversion.
// - with auto-trigger, source field picks trigger; 000 free running.
// - switching to free running never creates a trigger by itself.
`timescale 1ns/1ps
`default_nettype none

module adc_control #(
  parameter int ADDR_W = 9
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  output var  logic [31:0]       wb_dat_o,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  output var  logic              wb_ack_o,
  input  wire logic [7:1]        trigger_in,
  input  wire logic [9:0]        core_result,
  input  wire logic              global_irq_enable,
  input  wire logic              irq_vector_taken,
  output var  logic              conv_irq,
  output var  logic              converter_on,
  output var  logic              core_clk_en,
  output var  logic              conv_busy,
  output var  logic              conv_init,
  output var  logic              conv_sample,
  output var  logic [2:0]        pos_input,
  output var  logic [1:0]        neg_input,
  output var  logic [1:0]        gain_sel,
  output var  logic              single_ended,
  output var  logic              diff_mode,
  output var  logic              bandgap_sel,
  output var  logic              ground_sel,
  output var  logic [1:0]        ref_select,
  output var  logic              comparator_neg_from_mux
);
  import adc_ctl_pkg::*;

  if (ADDR_W < 9) begin : g_addr_check
    $error("ADDR_W must reach byte address 0x1F0");
  end

  function automatic route_t mux_decode(input logic [4:0] code);
    route_t r;
    r = '0;
    if (code <= MUX_SE_LAST) begin
      r.single = 1'b1;
      r.pos    = code[2:0];
    end else if (code <= MUX_GAIN_LAST) begin
      r.diff = 1'b1;
      r.pos  = {1'b0, code[2], code[0]};
      r.neg  = code[2] ? NEG_IN2 : NEG_IN0;
      r.gain = code[1] ? GAIN_200X : GAIN_10X;
    end else if (code <= MUX_DIFF_LAST) begin
      r.diff = 1'b1;
      r.pos  = code[2:0];
      r.neg  = (code <= MUX_NEG1_LAST) ? NEG_IN1 : NEG_IN2;
      r.gain = GAIN_1X;
    end else begin
      r.bandgap = (code == MUX_BANDGAP);
      r.ground  = (code == MUX_GROUND);
    end
    return r;
  endfunction

  // software-visible registers
  logic        enable_r;
  logic        auto_r;
  logic        flag_r;
  logic        ie_r;
  logic [2:0]  ps_r;
  logic        cmp_mux_r;
  logic [2:0]  trig_src_r;
  logic [1:0]  ref_r;
  logic        ladj_r;
  logic [4:0]  mux_r;
  // converter state
  conv_state_t state_r;
  logic [4:0]  cnt_r;
  logic [4:0]  len_r;
  logic        init_pend_r;
  logic [4:0]  act_mux_r;
  logic [1:0]  act_ref_r;
  logic [9:0]  result_r;
  logic        lock_r;
  logic [6:0]  trig_meta_r;
  logic [6:0]  trig_sync_r;
  logic        trig_prev_r;
  logic        ack_r;
  logic [7:0]  rd_byte_r;
  logic        tick;

  // bus decode
  wire       req     = wb_cyc_i && wb_stb_i;
  wire [6:0] idx     = wb_adr_i[8:2];
  wire       wr_take = req && wb_we_i && ack_r && wb_sel_i[0];
  wire       rd_take = req && !wb_we_i && ack_r;
  wire [7:0] wd      = wb_dat_i[7:0];
  wire       wr_a    = wr_take && (idx == IDX_CTRL_A);
  wire       wr_b    = wr_take && (idx == IDX_CTRL_B);
  wire       wr_isr  = wr_take && (idx == IDX_INPUT_SEL);
  wire       rd_lo   = rd_take && (idx == IDX_RESULT_LO);
  wire       rd_hi   = rd_take && (idx == IDX_RESULT_HI);

  wire       enable_nxt = wr_a ? wd[CSA_ENABLE] : enable_r;
  wire       busy       = (state_r == ST_CONVERT);

  // conversion sequencing
  wire       finish   = busy && tick && (cnt_r == 5'(len_r - 5'd1));
  // sampled level of the chosen source; free running has no edge source
  wire       trig_lvl = (trig_src_r == TRIG_FREE_RUN) ? 1'b0
                        : trig_sync_r[3'(trig_src_r - 3'h1)];
  wire       trig_edge = auto_r && trig_lvl && !trig_prev_r;
  // free running restarts on own completion, never on a source switch
  wire       free_go  = auto_r && (trig_src_r == TRIG_FREE_RUN) && finish;
  wire       sw_go    = wr_a && wd[CSA_START] && wd[CSA_ENABLE];
  wire       start    = enable_nxt && (sw_go || trig_edge || free_go)
                        && (!busy || finish);
  wire       init_nxt = init_pend_r || (wr_a && wd[CSA_ENABLE] && !enable_r);

  // flag: hardware set wins over either clear
  wire       flag_clr = irq_vector_taken || (wr_a && wd[CSA_FLAG]);
  wire       flag_nxt = finish || (flag_r && !flag_clr);

  // result shaping on the read path so left adjust acts at once
  wire [15:0] res_view = ladj_r ? {result_r, 6'h00} : {6'h00, result_r};
  route_t     act_route;
  assign act_route = mux_decode(act_mux_r);

  // offset-binary code from the core turned to two's complement
  wire [9:0] shaped = act_route.diff ? {~core_result[9], core_result[8:0]}
                                     : core_result;

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = RESET_BYTE;
    case (idx)
      IDX_RESULT_LO: rd_byte = res_view[7:0];
      IDX_RESULT_HI: rd_byte = res_view[15:8];
      IDX_CTRL_A:    rd_byte = {enable_r, busy, auto_r, flag_r, ie_r, ps_r};
      IDX_CTRL_B:    rd_byte = {1'b0, cmp_mux_r, 3'h0, trig_src_r};
      IDX_INPUT_SEL: rd_byte = {ref_r, ladj_r, mux_r};
      default:       rd_byte = RESET_BYTE;
    endcase
  end

  adc_prescaler u_prescaler (
    .clock   (clock),
    .rst_n   (rst_n),
    .run     (enable_r),
    .div_sel (ps_r),
    .tick    (tick)
  );

  // wishbone slave: ack one cycle after request, one cycle wide
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r     <= 1'b0;
      rd_byte_r <= RESET_BYTE;
    end else begin
      ack_r     <= req && !ack_r;
      rd_byte_r <= rd_byte;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = {24'h000000, rd_byte_r};

  // control registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_r   <= 1'b0;
      auto_r     <= 1'b0;
      ie_r       <= 1'b0;
      ps_r       <= 3'h0;
      cmp_mux_r  <= 1'b0;
      trig_src_r <= 3'h0;
      ref_r      <= 2'h0;
      ladj_r     <= 1'b0;
      mux_r      <= 5'h00;
      flag_r     <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      if (wr_a) begin
        enable_r <= wd[CSA_ENABLE];
        auto_r   <= wd[CSA_AUTO];
        ie_r     <= wd[CSA_IE];
        ps_r     <= wd[CSA_PS_HI:0];
      end
      if (wr_b) begin
        cmp_mux_r  <= wd[CSB_CMP_MUX];
        trig_src_r <= wd[CSB_TS_HI:0];
      end
      if (wr_isr) begin
        ref_r  <= wd[ISR_REF_HI:ISR_REF_LO];
        ladj_r <= wd[ISR_LADJ];
        mux_r  <= wd[ISR_MUX_HI:0];
      end
    end
  end

  // trigger synchroniser; only the second stage is ever looked at
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trig_meta_r <= 7'h00;
      trig_sync_r <= 7'h00;
      trig_prev_r <= 1'b0;
    end else begin
      trig_meta_r <= trigger_in;
      trig_sync_r <= trig_meta_r;
      trig_prev_r <= trig_lvl;
    end
  end

  // conversion engine
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      cnt_r       <= 5'h00;
      len_r       <= NORMAL_CYCLES;
      init_pend_r <= 1'b0;
      act_mux_r   <= 5'h00;
      act_ref_r   <= 2'h0;
    end else if (!enable_nxt) begin
      state_r     <= ST_IDLE;
      cnt_r       <= 5'h00;
      init_pend_r <= 1'b0;
      act_mux_r   <= mux_r;
      act_ref_r   <= ref_r;
    end else begin
      case (state_r)
        ST_IDLE: begin
          act_mux_r   <= mux_r;
          act_ref_r   <= ref_r;
          init_pend_r <= init_nxt;
          if (start) begin
            state_r     <= ST_CONVERT;
            cnt_r       <= 5'h00;
            len_r       <= init_nxt ? INIT_CYCLES : NORMAL_CYCLES;
            init_pend_r <= 1'b0;
          end
        end
        ST_CONVERT: begin
          if (finish) begin
            // pending channel change applies from here on
            act_mux_r <= mux_r;
            act_ref_r <= ref_r;
            cnt_r     <= 5'h00;
            len_r     <= NORMAL_CYCLES;
            state_r   <= start ? ST_CONVERT : ST_IDLE;
          end else if (tick) begin
            cnt_r <= 5'(cnt_r + 5'd1);
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // result register and read lock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= 10'h000;
      lock_r   <= 1'b0;
    end else begin
      // a result finishing while locked is lost, the flag still sets
      if (finish && !lock_r) begin
        result_r <= shaped;
      end
      if (rd_hi) begin
        lock_r <= 1'b0;
      end else if (rd_lo) begin
        lock_r <= 1'b1;
      end
    end
  end

  // outward signals, all registered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_irq                <= 1'b0;
      converter_on            <= 1'b0;
      core_clk_en             <= 1'b0;
      conv_busy               <= 1'b0;
      conv_init               <= 1'b0;
      conv_sample             <= 1'b0;
      pos_input               <= 3'h0;
      neg_input               <= 2'h0;
      gain_sel                <= 2'h0;
      single_ended            <= 1'b0;
      diff_mode               <= 1'b0;
      bandgap_sel             <= 1'b0;
      ground_sel              <= 1'b0;
      ref_select              <= 2'h0;
      comparator_neg_from_mux <= 1'b0;
    end else begin
      conv_irq     <= flag_r && ie_r && global_irq_enable;
      converter_on <= enable_r;
      core_clk_en  <= tick && busy;
      conv_busy    <= busy;
      conv_init    <= busy && (len_r == INIT_CYCLES);
      // core must hold its code until this strobe has been seen
      conv_sample  <= finish;
      pos_input    <= act_route.pos;
      neg_input    <= act_route.neg;
      gain_sel     <= act_route.gain;
      single_ended <= act_route.single;
      diff_mode    <= act_route.diff;
      bandgap_sel  <= act_route.bandgap;
      ground_sel   <= act_route.ground;
      ref_select   <= act_ref_r;
      // with the converter off the mux follows the register directly
      comparator_neg_from_mux <= cmp_mux_r && !enable_r;
    end
  end

endmodule

`default_nettype wire

// ---- tb/core_model.sv ----
/*
  converter core stand-in: offers a fresh 10-bit code after every conversion.
  assumes conv_sample pulses once per finished conversion.
*/
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       conv_sample,
  output var  logic [9:0] core_result
);
  // odd step so every bit toggles across a run
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      core_result <= 10'h155;
    else if (conv_sample)
      core_result <= core_result + 10'h0C3;
  end
endmodule
`default_nettype wire

// ---- tb/adc_control_asserts.sv ----
/*
  concurrent checks on the converter control ports.
  assumes binding into adc_control, single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_control_asserts
  import adc_ctl_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       global_irq_enable,
  input wire logic       conv_irq,
  input wire logic       converter_on,
  input wire logic       core_clk_en,
  input wire logic       conv_busy,
  input wire logic       conv_init,
  input wire logic       conv_sample,
  input wire logic [2:0] pos_input,
  input wire logic [1:0] neg_input,
  input wire logic [1:0] gain_sel,
  input wire logic       single_ended,
  input wire logic       diff_mode,
  input wire logic       bandgap_sel,
  input wire logic       ground_sel,
  input wire logic       comparator_neg_from_mux
);
  logic [5:0] ticks_r;
  logic       init_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ticks of the running conversion; a disable drops the count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ticks_r <= 6'h00;
      init_r  <= 1'b0;
    end else if (conv_sample || !converter_on) begin
      ticks_r <= 6'h00;
      init_r  <= 1'b0;
    end else begin
      ticks_r <= ticks_r + 6'(core_clk_en && conv_busy);
      init_r  <= init_r || conv_init;
    end
  end
  a_conv_length: assert property (
    conv_sample |-> ticks_r + 6'(core_clk_en && conv_busy) == (init_r ? 6'h19 : 6'h0D))
    else $error("bad length");
  a_tick_gap: assert property (
    core_clk_en |=> !core_clk_en) else $error("tick too fast");
  a_abort_idle: assert property (
    !converter_on [*2] |-> !conv_busy) else $error("busy while off");
  a_cmp_route: assert property (
    comparator_neg_from_mux |-> !converter_on) else $error("mux to comparator while on");
  a_irq_gate: assert property (
    !global_irq_enable |=> !conv_irq) else $error("irq without global enable");
  a_route_kind: assert property (
    $onehot0({single_ended, diff_mode, bandgap_sel, ground_sel})) else $error("route kind");
  a_gain_pair: assert property (
    gain_sel != GAIN_1X |-> diff_mode && neg_input != NEG_IN1) else $error("gain pair");
  a_route_hold: assert property (
    conv_busy && $past(conv_busy) && !conv_sample && !$past(conv_sample)
    |-> $stable({pos_input, neg_input, gain_sel})) else $error("route moved mid conversion");
endmodule
bind adc_control adc_control_asserts chk_i (
  .clock, .rst_n, .global_irq_enable, .conv_irq, .converter_on, .core_clk_en, .conv_busy,
  .conv_init, .conv_sample, .pos_input, .neg_input, .gain_sel, .single_ended, .diff_mode,
  .bandgap_sel, .ground_sel, .comparator_neg_from_mux
);
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
  self-checking bench: wishbone master tasks, one task per scenario.
  assumes core_model as converter core and the checker bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adc_ctl_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [8:0]  wb_adr_i = 9'h000;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic        wb_we_i = 1'b0;
  logic [3:0]  wb_sel_i = 4'hF;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic [7:1]  trigger_in = 7'h00;
  logic        global_irq_enable = 1'b1;
  logic        irq_vector_taken = 1'b0;
  logic [9:0]  core_result;
  logic        wb_ack_o, conv_irq, converter_on, core_clk_en, conv_busy, conv_init, conv_sample;
  logic [2:0]  pos_input;
  logic [1:0]  neg_input, gain_sel, ref_select;
  logic        single_ended, diff_mode, bandgap_sel, ground_sel, comparator_neg_from_mux;
  int          bad_count, num_checks, nconv, run_t, last_t;

  adc_control uut (
    .clock, .rst_n, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .trigger_in, .core_result, .global_irq_enable, .irq_vector_taken,
    .conv_irq, .converter_on, .core_clk_en, .conv_busy, .conv_init, .conv_sample, .pos_input,
    .neg_input, .gain_sel, .single_ended, .diff_mode, .bandgap_sel, .ground_sel, .ref_select,
    .comparator_neg_from_mux
  );
  core_model core (.clock, .rst_n, .conv_sample, .core_result);

  always #25 clock = ~clock;
  // ticks per finished conversion
  always @(posedge clock) begin
    if (conv_sample === 1'b1) begin
      nconv  <= nconv + 1;
      // last tick shares its cycle with the sample strobe
      last_t <= run_t + int'(core_clk_en === 1'b1 && conv_busy === 1'b1);
      run_t  <= 0;
    end else if (converter_on !== 1'b1)
      run_t <= 0;
    else if (core_clk_en === 1'b1 && conv_busy === 1'b1)
      run_t <= run_t + 1;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [9:0] code_at(input int k);
    return 10'h155 + 10'(k) * 10'h0C3;
  endfunction
  task automatic bus(input logic [6:0] idx, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h000000, d};
    wb_we_i  <= w;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      results();
    end
    @(posedge clock);
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(idx, 1'b1, d, q);
  endtask
  task automatic wait_s();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (conv_sample !== 1'b1 && n < 5000);
    if (conv_sample !== 1'b1) begin
      bad_count++;
      results();
    end
  endtask

  task automatic t_reset();
    logic [7:0] q;
    // 7D is unmapped
    for (logic [6:0] i = 7'h78; i <= 7'h7D; i++) begin
      bus(i, 1'b0, 8'h00, q);
      chk(q, RESET_BYTE);
    end
  endtask
  task automatic t_conv();
    logic [7:0] q, lo;
    wr(IDX_CTRL_A, 8'hC3);
    bus(IDX_CTRL_A, 1'b0, 8'h00, q);
    chk(q[CSA_START], 1'b1);
    wr(IDX_CTRL_A, 8'h83);
    bus(IDX_CTRL_A, 1'b0, 8'h00, q);
    chk(q[CSA_START], 1'b1);
    wait_s();
    bus(IDX_CTRL_A, 1'b0, 8'h00, q);
    chk({q[CSA_START], q[CSA_FLAG], 14'(last_t)}, 16'h4019);
    bus(IDX_RESULT_LO, 1'b0, 8'h00, lo);
    bus(IDX_RESULT_HI, 1'b0, 8'h00, q);
    chk({q, lo}, {6'h00, code_at(0)});
    wr(IDX_CTRL_A, 8'h93);
    bus(IDX_CTRL_A, 1'b0, 8'h00, q);
    chk(q[CSA_FLAG], 1'b0);
    wr(IDX_CTRL_A, 8'hC3);
    wait_s();
    bus(IDX_CTRL_A, 1'b0, 8'h00, q);
    chk(16'(last_t), 16'h000D);
  endtask
  task automatic t_adjust();
    logic [7:0] q, lo;
    logic [9:0] c;
    c = code_at(1);
    bus(IDX_RESULT_LO, 1'b0, 8'h00, lo);
    wr(IDX_CTRL_A, 8'hC3);
    wr(IDX_INPUT_SEL, 8'h21);
    bus(IDX_RESULT_LO, 1'b0, 8'h00, q);
    chk({q, lo}, {c[1:0], 6'h00, c[7:0]});
    chk(pos_input, 3'h0);
    wait_s();
    bus(IDX_RESULT_HI, 1'b0, 8'h00, q);
    chk({pos_input, q}, {3'h1, c[9:2]});
    bus(IDX_RESULT_LO, 1'b0, 8'h00, lo);
    bus(IDX_RESULT_HI, 1'b0, 8'h00, q);
    chk({q, lo}, {c, 6'h00});
    wr(IDX_INPUT_SEL, 8'h10);
    wr(IDX_CTRL_A, 8'hC3);
    wait_s();
    c = code_at(3);
    bus(IDX_RESULT_LO, 1'b0, 8'h00, lo);
    bus(IDX_RESULT_HI, 1'b0, 8'h00, q);
    chk({q, lo}, {6'h00, ~c[9], c[8:0]});
  endtask
  task automatic t_irq();
    logic [7:0] q;
    wr(IDX_CTRL_A, 8'h8B);
    bus(IDX_CTRL_A, 1'b0, 8'h00, q);
    chk(conv_irq, 1'b1);
    global_irq_enable <= 1'b0;
    bus(IDX_CTRL_A, 1'b0, 8'h00, q);
    chk(conv_irq, 1'b0);
    global_irq_enable <= 1'b1;
    irq_vector_taken  <= 1'b1;
    @(posedge clock);
    irq_vector_taken <= 1'b0;
    bus(IDX_CTRL_A, 1'b0, 8'h00, q);
    chk({conv_irq, q[CSA_FLAG]}, 2'h0);
  endtask
  task automatic t_abort();
    logic [7:0] q;
    int n0;
    n0 = nconv;
    wr(IDX_CTRL_B, 8'h40);
    wr(IDX_CTRL_A, 8'hC3);
    bus(IDX_CTRL_B, 1'b0, 8'h00, q);
    chk({comparator_neg_from_mux, q}, 9'h040);
    wr(IDX_CTRL_A, 8'h00);
    bus(IDX_CTRL_A, 1'b0, 8'h00, q);
    chk({converter_on, conv_busy, comparator_neg_from_mux, q}, 11'h100);
    // longest conversion at divide by 8
    repeat (200) @(posedge clock);
    chk(16'(nconv - n0), 16'h0000);
    wr(IDX_CTRL_B, 8'h00);
  endtask
  task automatic t_trig();
    logic [7:0] q;
    int n0;
    wr(IDX_CTRL_B, 8'h02);
    wr(IDX_CTRL_A, 8'hA3);
    trigger_in[2] <= 1'b1;
    wait_s();
    trigger_in[2] <= 1'b0;
    bus(IDX_CTRL_A, 1'b0, 8'h00, q);
    chk(16'(last_t), 16'h0019);
    wr(IDX_CTRL_B, 8'h00);
    repeat (200) @(posedge clock);
    chk(conv_busy, 1'b0);
    n0 = nconv;
    wr(IDX_CTRL_A, 8'hF3);
    wait_s();
    wait_s();
    wr(IDX_CTRL_A, 8'h00);
    chk(16'(nconv - n0), 16'h0002);
  endtask
  task automatic t_route();
    logic [7:0]  q;
    logic [4:0]  k;
    logic [10:0] e, m;
    logic        g;
    for (int c = 0; c < 32; c++) begin
      k = 5'(c);
      g = k >= 5'h08 && k <= 5'h0F;
      wr(IDX_INPUT_SEL, {k[1:0], 1'b0, k});
      bus(IDX_INPUT_SEL, 1'b0, 8'h00, q);
      e = {k <= 5'h07, k > 5'h07 && k <= 5'h1D, k == 5'h1E, k == 5'h1F,
           g ? {1'b0, k[2], k[0]} : k[2:0],
           g ? (k[2] ? NEG_IN2 : NEG_IN0) : (k <= 5'h17 ? NEG_IN1 : NEG_IN2),
           g ? (k[1] ? GAIN_200X : GAIN_10X) : GAIN_1X};
      m = k <= 5'h07 ? 11'h7F0 : (k <= 5'h1D ? 11'h7FF : 11'h780);
      chk({q[4:0], {single_ended, diff_mode, bandgap_sel, ground_sel, pos_input, neg_input,
           gain_sel} & m}, {k, e & m});
      chk({ref_select, q[7:5]}, {k[1:0], k[1:0], 1'b0});
    end
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_conv();
    t_adjust();
    t_irq();
    t_abort();
    t_trig();
    t_route();
    results();
  end
endmodule
`default_nettype wire
